// ---- hw/touch_cfg.svh ----
// Notes on behaviour
// - Target only; never begins a bus transfer
// - Address pair 0xBA/0xBB or 0x28/0x29, fixed
// - Matching address acknowledged on ninth clock
// - Unmatched address: no acknowledge, stay idle
// - Nine clocks per byte, data valid high
// - Pointer increments after every written byte the buffer accepts
// - Read continues while host keeps acknowledging
// - Interrupt output line signals events
// - Reset input is active low
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH
`define ADDR_PAIR_LOW    8'hBA
`define ADDR_PAIR_HIGH   8'h28
`define BIT_LAST         4'h7
`define BIT_ACK          4'h8
// Start parks the count here so the clock fall that ends it wraps to bit 0
`define BIT_PRE          4'hF
`define STRAP_WAIT       2'h3
`define FIFO_WIDTH       24
`define FIFO_DEPTH       8
`define PTR_STEP         16'h0001
`endif

// ---- hw/touch_pkg.sv ----
package touch_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REGH,
    ST_REGL,
    ST_WDATA,
    ST_RDATA
  } link_state_t;
endpackage

// ---- hw/touch_i2c_slave_port.sv ----
`timescale 1ns/1ps
`include "touch_cfg.svh"

module touch_wr_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             s_valid,
  output logic                  s_ready,
  input  wire logic [WIDTH-1:0] s_data,
  output logic                  m_valid,
  input  wire logic             m_ready,
  output logic      [WIDTH-1:0] m_data
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign s_ready = (count != CW'(DEPTH));
  assign push    = s_valid && s_ready;
  assign pop     = m_valid && m_ready;
  assign m_data  = mem[0];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (!push && pop) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= '0;
      m_valid <= 1'b0;
    end else begin
      count   <= next_count;
      m_valid <= (next_count != '0);
    end
  end

  // Shift-register storage keeps the head in a flop, so outputs stay registered
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    localparam int NX = (i < DEPTH - 1) ? i + 1 : i;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem[i] <= '0;
      end else if (pop) begin
        if (push && count == CW'(i + 1)) begin
          mem[i] <= s_data;
        end else begin
          mem[i] <= mem[NX];
        end
      end else if (push && count == CW'(i)) begin
        mem[i] <= s_data;
      end
    end
  end
endmodule

module touch_i2c_slave_port
  import touch_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic        INT_IN,
  output logic             INT_OUT,
  output logic             INT_OE,
  input  wire logic        TOUCH_EVENT,
  output logic             WR_VALID,
  input  wire logic        WR_READY,
  output logic      [15:0] WR_ADDR,
  output logic      [7:0]  WR_DATA,
  output logic      [15:0] RD_ADDR,
  input  wire logic [7:0]  RD_DATA,
  output logic             RD_STROBE
);
  logic        scl_meta;
  logic        scl_sync;
  logic        scl_prev;
  logic        sda_meta;
  logic        sda_sync;
  logic        sda_prev;
  logic        int_meta;
  logic        int_sync;
  logic [1:0]  strap_cnt;
  logic        strap_done;
  logic [7:0]  own_addr;
  link_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx_shift;
  logic [7:0]  tx_shift;
  logic [15:0] ptr;
  logic        is_read;
  logic        pend;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        byte_done;
  logic        ack_end;
  logic        addr_hit;
  logic        wr_req;
  logic        fifo_ready;
  logic        rd_load;
  logic [23:0] wr_word;

  // Pin inputs pass two flops; the second, and for SCL and SDA a third, feeds logic
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
      int_meta <= 1'b0;
      int_sync <= 1'b0;
    end else begin
      scl_meta <= SCL_IN;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= SDA_IN;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
      int_meta <= INT_IN;
      int_sync <= int_meta;
    end
  end

  assign rise      = scl_sync && !scl_prev;
  assign fall      = !scl_sync && scl_prev;
  assign start     = strap_done && scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop      = scl_sync && scl_prev && !sda_prev && sda_sync;
  assign byte_done = fall && bit_cnt == `BIT_LAST && state != ST_IDLE;
  assign ack_end   = fall && bit_cnt == `BIT_ACK && state != ST_IDLE;
  assign addr_hit  = rx_shift[7:1] == own_addr[7:1];
  assign wr_req    = byte_done && state == ST_WDATA;
  assign rd_load   = ack_end && is_read && (state == ST_ADDR || state == ST_RDATA);
  assign wr_word   = {ptr, rx_shift};

  // Strap sampled once the synchroniser has settled, then held
  // strap at release
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      own_addr   <= `ADDR_PAIR_LOW;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == `STRAP_WAIT) begin
        strap_done <= 1'b1;
        own_addr   <= int_sync ? `ADDR_PAIR_HIGH : `ADDR_PAIR_LOW;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bit_cnt  <= 4'h0;
      rx_shift <= 8'h00;
    end else if (start) begin
      bit_cnt <= `BIT_PRE;
    end else begin
      if (rise && bit_cnt < `BIT_ACK) begin
        rx_shift <= {rx_shift[6:0], sda_sync};
      end
      if (fall) begin
        bit_cnt <= (bit_cnt == `BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state   <= ST_IDLE;
      is_read <= 1'b0;
    end else if (start) begin
      // only a host start wakes the port
      state <= ST_ADDR;
    end else if (stop) begin
      state <= ST_IDLE;
    end else if (byte_done && state == ST_ADDR) begin
      if (!addr_hit) begin
        state <= ST_IDLE;
      end
      is_read <= rx_shift[0];
    end else if (rise && bit_cnt == `BIT_ACK && state == ST_RDATA && sda_sync) begin
      state <= ST_IDLE;
    end else if (ack_end) begin
      case (state)
        ST_ADDR:  state <= is_read ? ST_RDATA : ST_REGH;
        ST_REGH:  state <= ST_REGL;
        ST_REGL:  state <= ST_WDATA;
        default:  state <= state;
      endcase
    end
  end

  // Pointer survives a repeated start so a read follows the written address
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ptr <= 16'h0000;
    end else if (byte_done && state == ST_REGH) begin
      ptr[15:8] <= rx_shift;
    end else if (byte_done && state == ST_REGL) begin
      ptr[7:0] <= rx_shift;
    end else if (wr_req && fifo_ready) begin
      ptr <= ptr + `PTR_STEP;
    end else if (rd_load) begin
      ptr <= ptr + `PTR_STEP;
    end
  end

  // Open drain: output level is always low, only the enable moves
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SDA_OUT  <= 1'b0;
      SDA_OE   <= 1'b0;
      tx_shift <= 8'h00;
    end else if (start || stop) begin
      SDA_OE <= 1'b0;
    end else if (byte_done) begin
      case (state)
        ST_ADDR:  SDA_OE <= addr_hit;
        ST_REGH:  SDA_OE <= 1'b1;
        ST_REGL:  SDA_OE <= 1'b1;
        // Full buffer refuses the byte with not-acknowledge
        ST_WDATA: SDA_OE <= fifo_ready;
        default:  SDA_OE <= 1'b0;
      endcase
    end else if (rd_load) begin
      tx_shift <= RD_DATA;
      SDA_OE   <= !RD_DATA[7];
    end else if (ack_end) begin
      SDA_OE <= 1'b0;
    end else if (fall && state == ST_RDATA && bit_cnt < `BIT_LAST) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
      SDA_OE   <= !tx_shift[6];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RD_ADDR   <= 16'h0000;
      RD_STROBE <= 1'b0;
    end else begin
      RD_ADDR   <= ptr;
      RD_STROBE <= rd_load;
    end
  end

  // event line; a new event beats the clear
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pend    <= 1'b0;
      INT_OUT <= 1'b0;
      INT_OE  <= 1'b0;
    end else begin
      if (TOUCH_EVENT) begin
        pend <= 1'b1;
      end else if (rd_load && state == ST_ADDR) begin
        pend <= 1'b0;
      end
      INT_OUT <= pend;
      INT_OE  <= strap_done;
    end
  end

  touch_wr_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk     (CORE_CLK),
    .rst_n   (RESETN),
    .s_valid (wr_req),
    .s_ready (fifo_ready),
    .s_data  (wr_word),
    .m_valid (WR_VALID),
    .m_ready (WR_READY),
    .m_data  ({WR_ADDR, WR_DATA})
  );

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  a_idle_quiet:
    assert property (state == ST_IDLE && !$past(state == ST_RDATA) |-> !SDA_OE)
    else $error("data line driven while idle");
  a_addr_ack:
    assert property (byte_done && state == ST_ADDR && addr_hit |=> SDA_OE [*2])
    else $error("matching address not acknowledged");
  a_addr_ignore:
    assert property (byte_done && state == ST_ADDR && !addr_hit && !stop
                     |=> state == ST_IDLE && !SDA_OE)
    else $error("foreign address not ignored");
  a_nine_clocks:
    assert property (ack_end && !start |=> bit_cnt == 4'h0)
    else $error("byte framing count wrong");
  a_wr_step:
    assert property (wr_req && fifo_ready |=> ptr == $past(ptr) + `PTR_STEP)
    else $error("write pointer did not step");
  a_rd_step:
    assert property (rd_load |=> ptr == $past(ptr) + `PTR_STEP ##0 RD_STROBE)
    else $error("read pointer did not step");
  a_rd_stop:
    assert property (rise && bit_cnt == `BIT_ACK && state == ST_RDATA && sda_sync
                     && !start && !stop |=> state == ST_IDLE)
    else $error("read kept going after not-acknowledge");
  a_pair_fixed:
    assert property (strap_done |=> $stable(own_addr))
    else $error("address pair changed after strap");
  a_event_line:
    assert property (TOUCH_EVENT && strap_done |-> ##2 INT_OUT)
    else $error("event did not reach interrupt line");

  c_write: cover property (wr_req && fifo_ready);
  c_read: cover property (rd_load && state == ST_RDATA);
  c_full_refuse: cover property (wr_req && !fifo_ready);
  c_foreign: cover property (byte_done && state == ST_ADDR && !addr_hit);
endmodule

// ---- bench/i2c_host_model.sv ----
`timescale 1ns/1ps
module i2c_host_model #(
  // four quarters of 125 cycles give 400 kbit/s
  parameter int Q = 125
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic q();
    repeat (Q) @(posedge clk);
  endtask
  // data moves only while the clock is low
  task automatic put_bit(input logic b, output logic s);
    q();
    sda_oe <= !b;
    q();
    scl <= 1'b1;
    q();
    s = sda;
    q();
    scl <= 1'b0;
  endtask
  // start, also used as repeated start
  task automatic start();
    q();
    sda_oe <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b0;
  endtask
  // eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
    put_bit(ack_in, ack);
  endtask
  task automatic stop();
    q();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b0;
    q();
  endtask
endmodule

// ---- bench/touch_i2c_slave_port_tb.sv ----
`timescale 1ns/1ps
module touch_i2c_slave_port_tb;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        int_host = 1'b0;
  logic        touch_event = 1'b0;
  logic        wr_ready = 1'b0;
  logic        scl, host_oe, sda, sda_oe, sda_out, int_out, int_oe, int_wire;
  logic        wr_valid, rd_strobe, a;
  logic [15:0] wr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data, r;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_strobe = 0;

  always #2.5 core_clk = ~core_clk;
  // Open drain with pull-up; the interrupt pin is ours until the strap is taken
  assign sda = !(sda_oe | host_oe);
  assign int_wire = int_oe ? int_out : int_host;
  // Register file stand-in: contents follow the address
  assign rd_data = rd_addr[7:0] ^ 8'h5A;
  always @(posedge core_clk) if (rd_strobe === 1'b1) n_strobe <= n_strobe + 1;

  i2c_host_model #(.Q(125)) host (.clk(core_clk), .sda(sda), .scl(scl), .sda_oe(host_oe));

  touch_i2c_slave_port dut (
    .CORE_CLK(core_clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .INT_IN(int_wire), .INT_OUT(int_out),
    .INT_OE(int_oe), .TOUCH_EVENT(touch_event), .WR_VALID(wr_valid),
    .WR_READY(wr_ready), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_ADDR(rd_addr),
    .RD_DATA(rd_data), .RD_STROBE(rd_strobe)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // strap level held across release of reset
  task automatic do_reset(input logic strap);
    @(posedge core_clk);
    resetn <= 1'b0;
    int_host <= strap;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (20) @(posedge core_clk);
    check(int_oe, 1'b1);
    check(sda_out, 1'b0);
  endtask

  // Nine bytes into a stalled consumer: the ninth finds the buffer full
  task automatic t_write();
    int n;
    n = 0;
    host.start();
    host.xfer(8'hBA, 1'b1, r, a);
    check(a, 1'b0);
    host.xfer(8'h12, 1'b1, r, a);
    host.xfer(8'hFE, 1'b1, r, a);
    for (int i = 0; i < 9; i++) begin
      host.xfer(8'hA0 + 8'(i), 1'b1, r, a);
      check(a, i == 8);
    end
    host.stop();
    wr_ready <= 1'b1;
    for (int k = 0; k < 100 && n < 8; k++) begin
      @(negedge core_clk);
      if (wr_valid === 1'b1) begin
        check(wr_addr, 16'h12FE + 16'(n));
        check(wr_data, 8'hA0 + 8'(n));
        n++;
      end
    end
    check(16'(n), 16'd8);
    // The last word leaves the buffer on the next edge
    @(negedge core_clk);
    check(wr_valid, 1'b0);
  endtask

  // pointer walk across a byte boundary, event cleared by the read
  task automatic t_read();
    logic [7:0] e;
    int         s0;
    @(posedge core_clk);
    touch_event <= 1'b1;
    @(posedge core_clk);
    touch_event <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(int_out, 1'b1);
    s0 = n_strobe;
    host.start();
    host.xfer(8'hBA, 1'b1, r, a);
    host.xfer(8'h00, 1'b1, r, a);
    host.xfer(8'hFF, 1'b1, r, a);
    host.start();
    host.xfer(8'hBB, 1'b1, r, a);
    check(a, 1'b0);
    for (int i = 0; i < 3; i++) begin
      e = (8'hFF + 8'(i)) ^ 8'h5A;
      host.xfer(8'hFF, i == 2, r, a);
      check(r, e);
    end
    host.stop();
    check(16'(n_strobe - s0), 16'd3);
    check(int_out, 1'b0);
  endtask

  task automatic t_nomatch();
    host.start();
    host.xfer(8'h28, 1'b1, r, a);
    check(a, 1'b1);
    host.stop();
  endtask

  // Second reset with the interrupt pin high selects the other pair
  task automatic t_strap();
    do_reset(1'b1);
    host.start();
    host.xfer(8'h28, 1'b1, r, a);
    check(a, 1'b0);
    host.start();
    host.xfer(8'hBA, 1'b1, r, a);
    check(a, 1'b1);
    host.stop();
  endtask

  initial begin
    do_reset(1'b0);
    t_write();
    t_read();
    t_nomatch();
    t_strap();
    summarize();
  end
endmodule
